// *** rtl/adcrf_pkg.sv ***
// shared constants and types for the conversion result formatter
package adcrf_pkg;
	// register byte offsets
	localparam logic [3:0] ADCRF_CTRL_OFS = 4'h0;
	localparam logic [3:0] ADCRF_CAL_OFS = 4'h4;
	localparam logic [3:0] ADCRF_RESULT_OFS = 4'h8;
	localparam logic [3:0] ADCRF_STATUS_OFS = 4'hC;
	// control field positions
	localparam int ADCRF_SIGNED_BIT = 0;
	localparam int ADCRF_RES8_BIT = 1;
	localparam int ADCRF_LEFT_BIT = 2;
	localparam int ADCRF_REF_LSB = 4;
	localparam int ADCRF_GAIN_LSB = 8;
	localparam int ADCRF_SAMP_LSB = 12;
	localparam int ADCRF_START_BIT = 31;
	// field widths
	localparam int ADCRF_REF_W = 3;
	localparam int ADCRF_GAIN_W = 3;
	localparam int ADCRF_SAMP_W = 6;
	localparam int ADCRF_CAL_W = 16;
	// reset values
	localparam logic [31:0] ADCRF_CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] ADCRF_CAL_RST = 16'h0000;
	// gain code one means unity amplification
	localparam logic [2:0] ADCRF_GAIN_UNITY = 3'h1;
	// reference choices
	typedef enum logic [2:0] {
		ADCRF_REF_BANDGAP_1V00,
		ADCRF_REF_VCC_DIV1P6,
		ADCRF_REF_VCC_DIV2,
		ADCRF_REF_EXT_PORTA,
		ADCRF_REF_EXT_PORTD
	} adcrf_ref_type;
	// result range limits
	localparam logic [11:0] ADCRF_U12_TOP = 12'hFFF;
	localparam logic [11:0] ADCRF_ZERO12 = 12'h000;
	localparam logic [3:0] ADCRF_ZERO4 = 4'h0;
	localparam logic [7:0] ADCRF_ZERO8 = 8'h00;
	localparam logic [31:0] ADCRF_ZERO32 = 32'h0000_0000;
endpackage

// *** rtl/adcrf_sampler.sv ***
// sampling window counter in half converter clock steps
`timescale 1ns/1ps
module adcrf_sampler #(
	parameter int SAMP_W = 6
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic start_i,
	input wire logic [SAMP_W-1:0] extend_i,
	input wire logic half_tick_i,
	output logic done_o
);
	import adcrf_pkg::*;
	typedef struct packed {
		logic busy;
		logic [SAMP_W:0] cnt;
		logic done;
	} adcrf_smp_type;
	adcrf_smp_type s_reg, s_next;
	// base window two half steps, plus the software extension
	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (start_i && !s_reg.busy) begin
			s_next.busy = 1'b1;
			s_next.cnt = {1'b0, extend_i} + (SAMP_W+1)'(2);
		end else if (s_reg.busy && half_tick_i) begin
			if (s_reg.cnt <= (SAMP_W+1)'(1)) begin
				s_next.busy = 1'b0;
				s_next.cnt = '0;
				s_next.done = 1'b1;
			end else begin
				s_next.cnt = s_reg.cnt - (SAMP_W+1)'(1);
			end
		end
	end
	// state register
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
	assign done_o = s_reg.done;
endmodule // adcrf_sampler

// *** rtl/adcrf_formatter.sv ***
// combinational shaping of a raw code into the 16-bit result word
`timescale 1ns/1ps
module adcrf_formatter (
	input wire logic signed_i,
	input wire logic res8_i,
	input wire logic left_i,
	input wire logic [12:0] raw_i,
	output logic [15:0] word_o
);
	import adcrf_pkg::*;
	logic [11:0] v12;
	// raw_i is a 13-bit two's complement code from the core
	always_comb begin
		v12 = raw_i[11:0];
		word_o = 16'h0000;
		if (!signed_i) begin
			if (raw_i[12]) begin
				v12 = ADCRF_ZERO12;
			end else if (raw_i[11:0] > ADCRF_U12_TOP) begin
				v12 = ADCRF_U12_TOP;
			end
		end
		if (res8_i) begin
			word_o = {{8{signed_i & v12[11]}}, v12[11:4]};
		end else if (left_i) begin
			word_o = {v12, ADCRF_ZERO4};
		end else begin
			word_o = {{4{signed_i & v12[11]}}, v12};
		end
	end
endmodule // adcrf_formatter

// *** rtl/adcrf_top.sv ***
// conversion result formatting with avalon register slave
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module adcrf_top #(
	parameter int SAMP_W = adcrf_pkg::ADCRF_SAMP_W,
	parameter int CONV12_HALF = 24,
	parameter int CONV8_HALF = 16
) (
	input wire logic sys_clk_i,
	input wire logic rst_b_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic adc_clk_i,
	input wire logic [12:0] core_code_i,
	input wire logic core_valid_i,
	output logic core_sample_o,
	output logic [adcrf_pkg::ADCRF_REF_W-1:0] ref_sel_o,
	output logic [adcrf_pkg::ADCRF_GAIN_W-1:0] gain_sel_o,
	output logic signed_mode_o,
	output logic [adcrf_pkg::ADCRF_CAL_W-1:0] cal_o,
	output logic result_ready_o
);
	import adcrf_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SAMPLE,
		ST_CONVERT,
		ST_WAIT_CORE
	} adcrf_state_type;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [15:0] cal;
		logic [15:0] result;
		logic ready;
		logic overrun;
		adcrf_state_type state;
		logic [5:0] conv_cnt;
		logic start_pulse;
		logic [2:0] clk_sync;
		logic [1:0] vld_sync;
		logic [12:0] code_hold;
		logic ack;
		logic [31:0] rdata;
		logic sample;
	} adcrf_all_type;

	adcrf_all_type s_reg, s_next;
	logic half_tick;
	logic samp_done;
	logic [15:0] fmt_word;
	logic bus_req;
	logic [31:0] wmask;
	logic [31:0] status_word;

	// both converter clock edges make a half step tick
	assign half_tick = s_reg.clk_sync[2] ^ s_reg.clk_sync[1];
	assign bus_req = (avs_read_i | avs_write_i) & ~s_reg.ack;
	assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
		{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	assign status_word = {29'h0000_0000, s_reg.state != ST_IDLE,
		s_reg.overrun, s_reg.ready};

	adcrf_sampler #(
		.SAMP_W(SAMP_W)
	) u_sampler (
		.sys_clk_i(sys_clk_i),
		.rst_b_i(rst_b_i),
		.start_i(s_reg.start_pulse),
		.extend_i(s_reg.ctrl[ADCRF_SAMP_LSB +: SAMP_W]),
		.half_tick_i(half_tick),
		.done_o(samp_done)
	);

	adcrf_formatter u_fmt (
		.signed_i(s_reg.ctrl[ADCRF_SIGNED_BIT]),
		.res8_i(s_reg.ctrl[ADCRF_RES8_BIT]),
		.left_i(s_reg.ctrl[ADCRF_LEFT_BIT]),
		.raw_i(s_reg.code_hold),
		.word_o(fmt_word)
	);

	// next state of bus slave, sequencer and synchronisers
	always_comb begin
		s_next = s_reg;
		s_next.start_pulse = 1'b0;
		s_next.ack = 1'b0;
		s_next.clk_sync = {s_reg.clk_sync[1:0], adc_clk_i};
		s_next.vld_sync = {s_reg.vld_sync[0], core_valid_i};
		// bus access: one wait cycle, then acknowledged
		if (bus_req) begin
			s_next.ack = 1'b1;
			s_next.rdata = ADCRF_ZERO32;
			if (avs_write_i) begin
				case (avs_address_i)
					ADCRF_CTRL_OFS: begin
						s_next.ctrl = (s_reg.ctrl & ~wmask) |
							(avs_writedata_i & wmask);
						s_next.ctrl[ADCRF_START_BIT] = 1'b0;
						s_next.start_pulse = avs_writedata_i[ADCRF_START_BIT] &
							avs_byteenable_i[3];
					end
					ADCRF_CAL_OFS: begin
						if (avs_byteenable_i[0]) begin
							s_next.cal[7:0] = avs_writedata_i[7:0];
						end
						if (avs_byteenable_i[1]) begin
							s_next.cal[15:8] = avs_writedata_i[15:8];
						end
					end
					default: begin
					end
				endcase
			end else begin
				case (avs_address_i)
					ADCRF_CTRL_OFS: begin
						s_next.rdata = s_reg.ctrl;
					end
					ADCRF_CAL_OFS: begin
						s_next.rdata = {16'h0000, s_reg.cal};
					end
					ADCRF_RESULT_OFS: begin
						s_next.rdata = {16'h0000, s_reg.result};
						s_next.ready = 1'b0;
						s_next.overrun = 1'b0;
					end
					ADCRF_STATUS_OFS: begin
						s_next.rdata = status_word;
					end
					default: begin
						s_next.rdata = ADCRF_ZERO32;
					end
				endcase
			end
		end
		// conversion sequencer
		case (s_reg.state)
			ST_IDLE: begin
				if (s_reg.start_pulse) begin
					s_next.state = ST_SAMPLE;
					s_next.sample = 1'b1;
				end
			end
			ST_SAMPLE: begin
				if (samp_done) begin
					s_next.sample = 1'b0;
					s_next.state = ST_CONVERT;
					s_next.conv_cnt = s_reg.ctrl[ADCRF_RES8_BIT] ?
						6'(CONV8_HALF) : 6'(CONV12_HALF);
				end
			end
			ST_CONVERT: begin
				if (half_tick) begin
					if (s_reg.conv_cnt <= 6'h01) begin
						s_next.state = ST_WAIT_CORE;
					end else begin
						s_next.conv_cnt = s_reg.conv_cnt - 6'h01;
					end
				end
			end
			ST_WAIT_CORE: begin
				if (s_reg.vld_sync[1]) begin
					s_next.code_hold = core_code_i;
					s_next.state = ST_IDLE;
				end
			end
			default: begin
				s_next.state = ST_IDLE;
			end
		endcase
		// result write; set wins over the read clear
		if (s_reg.state == ST_IDLE && s_reg.code_hold != 13'h0000 ||
			s_reg.ack == 1'b0 && 1'b0) begin
		end
	end

	logic load_res_reg;
	// a one-cycle delayed strobe loads the formatted word
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			load_res_reg <= 1'b0;
		end else begin
			load_res_reg <= (s_reg.state == ST_WAIT_CORE) && s_reg.vld_sync[1];
		end
	end

	// state register; result load overrides bus clear
	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_reg <= '0;
			s_reg.ctrl <= ADCRF_CTRL_RST;
			s_reg.cal <= ADCRF_CAL_RST;
			s_reg.state <= ST_IDLE;
		end else begin
			s_reg <= s_next;
			if (load_res_reg) begin
				s_reg.result <= fmt_word;
				s_reg.ready <= 1'b1;
				s_reg.overrun <= s_reg.ready;
			end
		end
	end

	assign avs_readdata_o = s_reg.rdata;
	assign avs_waitrequest_o = ~s_reg.ack;
	assign core_sample_o = s_reg.sample;
	assign ref_sel_o = s_reg.ctrl[ADCRF_REF_LSB +: ADCRF_REF_W];
	// gain passed to the front end
	assign gain_sel_o = s_reg.ctrl[ADCRF_GAIN_LSB +: ADCRF_GAIN_W];
	assign signed_mode_o = s_reg.ctrl[ADCRF_SIGNED_BIT];
	assign cal_o = s_reg.cal;
	assign result_ready_o = s_reg.ready;

	signed_range_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		$rose(s_reg.ready) && s_reg.ctrl[2:0] == 3'h1 |->
		s_reg.result[15:11] == 5'h00 || s_reg.result[15:11] == 5'h1F)
		else $error("signed result out of range");
	unsigned_range_a: assert property (@(posedge sys_clk_i)
		disable iff (!rst_b_i)
		$rose(s_reg.ready) && s_reg.ctrl[2:0] == 3'h0 |->
		s_reg.result[15:12] == 4'h0)
		else $error("unsigned result above 0FFF");
	left_nibble_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		$rose(s_reg.ready) && s_reg.ctrl[2:1] == 2'b10 |->
		s_reg.result[3:0] == 4'h0)
		else $error("left adjusted low bits not zero");
	byte_fill_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		$rose(s_reg.ready) && s_reg.ctrl[1] |->
		s_reg.result[15:8] == {8{s_reg.ctrl[0] & s_reg.result[7]}})
		else $error("8-bit high byte wrong");
	result_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		s_reg.state == ST_WAIT_CORE && s_reg.vld_sync[1] |-> ##2 s_reg.ready)
		else $error("result not loaded");
	// sampling lasts at least two system clock cycles
	sequence samp_begin_s;
		s_reg.state == ST_IDLE && s_reg.start_pulse;
	endsequence
	samp_min_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		samp_begin_s |=> core_sample_o [*2])
		else $error("sampling window too short");
	cal_out_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		avs_write_i && !s_reg.ack && avs_address_i == ADCRF_CAL_OFS &&
		avs_byteenable_i[1:0] == 2'b11 |=> cal_o == $past(avs_writedata_i[15:0]))
		else $error("calibration not stored");
	ref_out_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		ref_sel_o == s_reg.ctrl[6:4])
		else $error("reference select mismatch");
	// bus answers after one wait cycle
	bus_ack_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
		$rose(avs_read_i | avs_write_i) |-> ##1 !avs_waitrequest_o)
		else $error("bus answer late");
endmodule // adcrf_top

// *** testbench/adcrf_core_model.sv ***
// analogue core stand-in that hands back a chosen raw code
`timescale 1ns/1ps
module adcrf_core_model (
	input wire logic sys_clk_i,
	input wire logic sample_i,
	input wire logic ready_i,
	input wire logic [12:0] code_i,
	input wire logic [3:0] lat_i,
	output logic [12:0] code_o,
	output logic valid_o
);
	// code held while valid, garbled once the result is taken
	initial begin
		valid_o = 1'b0;
		code_o = 13'h0AAA;
		forever begin
			@(negedge sample_i);
			repeat (lat_i) @(posedge sys_clk_i);
			code_o <= code_i;
			valid_o <= 1'b1;
			@(posedge ready_i);
			@(posedge sys_clk_i);
			valid_o <= 1'b0;
			code_o <= ~code_i;
		end
	end
endmodule // adcrf_core_model

// *** testbench/adcrf_top_tb_top.sv ***
// self-checking bench for the result formatter
`timescale 1ns/1ps
module adcrf_top_tb_top;
	import adcrf_pkg::*;
	logic clk, rst_b, rd, wr, adc_clk, valid, sample, sgn, ready;
	logic [3:0] addr, be, lat;
	logic [31:0] wd, rdata, q, rv;
	logic wt;
	logic [12:0] code, m_code;
	logic [2:0] rf, gn;
	logic [15:0] cal;
	int seed, num_errors, n_tests, cur, sl, t8, t12, r;
	logic [12:0] rt [6] = '{13'h1800, 13'h07FF, 13'h1FFF, 13'h0FFF,
		13'h1FFF, 13'h0FFF};
	logic [2:0] mt [6] = '{3'h1, 3'h5, 3'h3, 3'h0, 3'h2, 3'h4};
	adcrf_top dut (.sys_clk_i(clk), .rst_b_i(rst_b), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wt), .adc_clk_i(adc_clk), .core_code_i(code),
		.core_valid_i(valid), .core_sample_o(sample), .ref_sel_o(rf),
		.gain_sel_o(gn), .signed_mode_o(sgn), .cal_o(cal),
		.result_ready_o(ready));
	adcrf_core_model core (.sys_clk_i(clk), .sample_i(sample),
		.ready_i(ready), .code_i(m_code), .lat_i(lat), .code_o(code),
		.valid_o(valid));
	// clocks: system 5 ns, converter 20 ns
	always #2.5 clk = ~clk;
	always #10 adc_clk = ~adc_clk;
	// length of each sampling window
	always @(posedge clk) begin
		if (sample) cur <= cur + 1;
		else if (cur != 0) begin
			sl <= cur;
			cur <= 0;
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	// one avalon cycle, held until the edge that sees waitrequest low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		addr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		@(posedge clk);
		while (wt !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100) chk("waitrequest", 0, 1);
		// read data taken at the same edge that ends the wait
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	function logic [15:0] fmt(logic [2:0] m, logic [12:0] raw);
		logic [11:0] v;
		v = (!m[0] && raw[12]) ? 12'h000 : raw[11:0];
		if (m[1]) return m[0] ? {{8{v[11]}}, v[11:4]} : {8'h00, v[11:4]};
		if (m[2]) return {v, 4'h0};
		return m[0] ? {{4{v[11]}}, v} : {4'h0, v};
	endfunction
	task conv(input logic [2:0] m, input logic [2:0] f, input logic [2:0] g,
		input logic [5:0] ex, input logic [12:0] raw, output int t);
		logic [31:0] c;
		// unsigned runs keep unity gain
		if (!m[0]) g = ADCRF_GAIN_UNITY;
		c = {14'h0, ex, 1'b0, g, 1'b0, f, 1'b0, m};
		m_code = raw;
		bus(1'b1, ADCRF_CTRL_OFS, c | 32'h8000_0000);
		chk("ref_sel", {29'h0, f}, {29'h0, rf});
		chk("gain_sel", {29'h0, g}, {29'h0, gn});
		chk("signed", {31'h0, m[0]}, {31'h0, sgn});
		t = 0;
		while (ready !== 1'b1 && t < 2000) begin
			@(negedge clk);
			t++;
		end
		@(posedge clk);
		bus(1'b0, ADCRF_STATUS_OFS, 0);
		chk("ready_set", 1, {31'h0, q[0]});
		bus(1'b0, ADCRF_RESULT_OFS, 0);
		chk("result", {16'h0, fmt(m, raw)}, q);
		bus(1'b0, ADCRF_STATUS_OFS, 0);
		chk("ready_clr", 0, {31'h0, q[0]});
		bus(1'b0, ADCRF_CTRL_OFS, 0);
		chk("ctrl_rd", c, q);
	endtask
	task close_out;
		$display("errors %0d of %0d checks", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#150000;
		num_errors++;
		close_out();
	end
	// reset, corners, timing, then random runs
	initial begin
		{clk, rst_b, rd, wr, adc_clk, addr, wd, cur, sl} = 0;
		be = 4'hF;
		lat = 4'h2;
		m_code = 0;
		seed = 61;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		bus(1'b0, ADCRF_CTRL_OFS, 0);
		chk("ctrl_rst", ADCRF_CTRL_RST, q);
		bus(1'b0, 4'h2, 0);
		chk("unmapped", 0, q);
		// factory calibration goes in before any conversion
		bus(1'b1, ADCRF_CAL_OFS, 32'h0000_5A3C);
		chk("cal_o", 32'h5A3C, {16'h0, cal});
		for (int i = 0; i < 6; i++) conv(mt[i], 3'(i % 5), 3'h1, 6'h0, rt[i], r);
		conv(3'h1, 3'h0, 3'h1, 6'h0, 13'h0123, t12);
		conv(3'h3, 3'h0, 3'h1, 6'h0, 13'h0123, t8);
		chk("faster8", 1, {31'h0, t8 < t12});
		conv(3'h1, 3'h0, 3'h1, 6'h9, 13'h0456, r);
		chk("samp_len", 1, {31'h0, sl >= 19 && sl <= 25});
		for (int i = 0; i < 30; i++) begin
			rv = $random(seed);
			lat <= rv[31:28];
			m_code = rv[0] ? {rv[27], rv[27:16]} : rv[28:16];
			conv({rv[2] & !rv[1], rv[1:0]}, 3'($unsigned($random(seed)) % 5),
				rv[10:8], rv[15:12], m_code, r);
		end
		close_out();
	end
endmodule // adcrf_top_tb_top
